//--- design/esu_pkg.sv
// Constants for the egress statistics index and update block.
// Assumes all users refer to names as esu_pkg::name.
package esu_pkg;
  localparam int unsigned ADR_W      = 8;
  localparam int unsigned DAT_W      = 32;
  localparam int unsigned SVC_IDX_W  = 10;
  localparam int unsigned INGRESS_SERVICE_INDEX_W     = 12;
  localparam int unsigned VID_W      = 12;
  localparam int unsigned PRIO_W     = 3;
  localparam int unsigned DP_W       = 2;
  localparam int unsigned COS_W      = 3;
  localparam int unsigned COS_OFS_W  = 4;
  localparam int unsigned PT_W       = 3;
  localparam int unsigned ACT_W      = 3;
  localparam int unsigned LEN_W      = 14;
  localparam int unsigned FRM_CNT_W  = 32;
  localparam int unsigned OCT_CNT_W  = 40;
  localparam int unsigned PORT_IDX_W = 5;
  localparam int unsigned PORT_IDX_N = 17;
  localparam int unsigned PORT_CFG_W = 7;
  localparam logic [PORT_IDX_W-1:0] ABORT_IDX = 5'h10;
  localparam logic [FRM_CNT_W-1:0]  FRM_ONE   = 32'h0000_0001;
  // Pipeline actions
  localparam logic [ACT_W-1:0] ACT_NONE      = 3'h0;
  localparam logic [ACT_W-1:0] ACT_XTR       = 3'h1;
  localparam logic [ACT_W-1:0] ACT_XTR_LATE  = 3'h2;
  localparam logic [ACT_W-1:0] ACT_UP_ENDPOINT_EXTRACT_ACTION = 3'h3;
  localparam logic [ACT_W-1:0] ACT_LOOPBACK_ASSEMBLY_ACTION   = 3'h4;
  localparam logic [ACT_W-1:0] ACT_INJ       = 3'h5;
  localparam logic [ACT_W-1:0] ACT_QUEUE_LOOPBACK_ACTION    = 3'h6;
  // Pipeline points, ordered early to late
  localparam logic [PT_W-1:0] PT_IN_MIP  = 3'h1;
  localparam logic [PT_W-1:0] PT_OU_SW   = 3'h3;
  localparam logic [PT_W-1:0] PT_OU_VOE  = 3'h5;
  localparam logic [PT_W-1:0] PT_VRAP    = 3'h7;
  // Abort sources
  localparam logic [1:0] ABT_OQS   = 2'h0;
  localparam logic [1:0] ABT_MATCH = 2'h1;
  localparam logic [1:0] ABT_MIP   = 2'h2;
  localparam logic [1:0] ABT_OAM   = 2'h3;
  // Service index selection modes
  localparam logic [1:0] MODE_SVC      = 2'h0;
  localparam logic [1:0] MODE_SVC_ONLY = 2'h1;
  localparam logic [1:0] MODE_INGRESS_SERVICE_INDEX     = 2'h2;
  localparam logic [1:0] MODE_VID      = 2'h3;
  // Register map
  localparam logic [ADR_W-1:0] A_CTRL  = 8'h00;
  localparam logic [ADR_W-1:0] A_COS   = 8'h04;
  localparam logic [ADR_W-1:0] A_STAT  = 8'h08;
  localparam logic [ADR_W-1:0] A_PORT0 = 8'h10;
  localparam int unsigned REG_STRIDE   = 4;
  localparam int unsigned CTRL_MODE    = 0;
  localparam int unsigned CTRL_STKDIS  = 2;
  localparam int unsigned CTRL_ABTEN   = 3;
  localparam int unsigned CTRL_DPMAP   = 4;
  localparam int unsigned PORT_STK     = 0;
  localparam int unsigned PORT_XTR     = 1;
  localparam int unsigned PORT_INJ     = 4;
  localparam logic [7:0] CTRL_RST = 8'hc0;
  localparam logic [DAT_W-1:0] COS_RST = 32'h7654_3210;
  localparam logic [PORT_CFG_W-1:0] PORT_RST =
    {PT_OU_VOE, PT_OU_SW, 1'b0};
endpackage

//--- design/esu_idx_sel.sv
// Service counter index and color selection, purely combinational.
// Assumes inputs come from the same clock domain as its user.
`timescale 1ns/1ps
module esu_idx_sel (
  input  wire logic [1:0]                     mode_i,
  input  wire logic [3:0]                     drop_level_color_map_i,
  input  wire logic [esu_pkg::DP_W-1:0]       dp_i,
  input  wire logic [esu_pkg::COS_W-1:0]      cos_i,
  input  wire logic [esu_pkg::DAT_W-1:0]      cos_tbl_i,
  input  wire logic [esu_pkg::INGRESS_SERVICE_INDEX_W-1:0]     ingress_service_index_i,
  input  wire logic [esu_pkg::VID_W-1:0]      vid_i,
  input  wire logic                           push_i,
  input  wire logic [esu_pkg::VID_W-1:0]      push_vid_i,
  input  wire logic                           routed_i,
  input  wire logic [esu_pkg::VID_W-1:0]      rleg_vid_i,
  input  wire logic                           dmac_mc_i,
  input  wire logic                           avail_i,
  input  wire logic [esu_pkg::SVC_IDX_W-1:0]  base_i,
  output logic      [esu_pkg::SVC_IDX_W-1:0]  idx_o,
  output logic                                color_o,
  output logic                                ok_o
);
  logic [esu_pkg::COS_OFS_W-1:0] ofs;
  logic [esu_pkg::VID_W-1:0]     vid_sel;

  always_comb begin
    ofs = cos_tbl_i[cos_i*esu_pkg::COS_OFS_W +: esu_pkg::COS_OFS_W];
    vid_sel = routed_i ? rleg_vid_i : (push_i ? push_vid_i : vid_i);
    idx_o = ingress_service_index_i[esu_pkg::SVC_IDX_W-1:0];
    color_o = dmac_mc_i;
    ok_o = 1'b1;
    case (mode_i)
      esu_pkg::MODE_SVC, esu_pkg::MODE_SVC_ONLY: begin
        color_o = drop_level_color_map_i[dp_i];
        if (avail_i) begin
          idx_o = base_i + esu_pkg::SVC_IDX_W'(ofs);
        end
        // Without an index, mode 1 skips counting
        ok_o = avail_i || (mode_i == esu_pkg::MODE_SVC);
      end
      esu_pkg::MODE_INGRESS_SERVICE_INDEX: begin
        idx_o = ingress_service_index_i[esu_pkg::SVC_IDX_W-1:0];
      end
      esu_pkg::MODE_VID: begin
        idx_o = vid_sel[esu_pkg::SVC_IDX_W-1:0];
      end
      default: begin
        ok_o = 1'b0;
      end
    endcase
  end
endmodule

//--- design/esu_top.sv
// Egress statistics index selection and update decision.
// Assumes frame and match inputs come from same-clock pipeline logic,
// one frame per cycle, and a Wishbone classic master on clk_i.
`timescale 1ns/1ps
// Notes on behaviour
// - No local counters; events go to store
// - Seventeen port indexes: color, priority, abort
// - Service indexes: two colors times 1024
// - Frame and octet counts sent together
// - Stacking disable plus header enable blocks service
// - Abort enable excludes OAM processor discards
// - Extract point defaults software-out; earliest counts all
// - Inject point defaults OAM-out; latest counts all
// - Port index: port, priority, shared color
// - Mode 0: base plus class offset
// - Fallback ingress index; color from drop map
// - Mode 1: no index, no service count
// - Mode 2: ingress index, multicast bit color
// - Mode 3: VID from classified, pushed, routed
// - Port counts: transmitted, non-extract frames, plus aborts at abort index
// - Service counts: physical, mode ok, transmitted
// - Extracts counted at or after extract point
// - Injects counted at or before inject point
// - Abort index counts aborts, rewriter gated
// - Match key carries protection active bit
// - Protection selects alternate indexes and base
// - Extracted frames absent at later points
module esu_top #(
  parameter int unsigned NPORT   = 8,
  parameter int unsigned PORT_W  = 3,
  parameter int unsigned ENCAP_W = 12,
  parameter int unsigned MEP_W   = 10
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            ce_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [esu_pkg::ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [esu_pkg::DAT_W-1:0]       wb_dat_i,
  output logic      [esu_pkg::DAT_W-1:0]       wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic                            frm_vld_i,
  input  wire logic [PORT_W-1:0]               frm_port_i,
  input  wire logic                            frm_phys_i,
  input  wire logic [esu_pkg::PRIO_W-1:0]      frm_prio_i,
  input  wire logic [esu_pkg::DP_W-1:0]        frm_dp_i,
  input  wire logic [esu_pkg::COS_W-1:0]       frm_cos_i,
  input  wire logic [esu_pkg::INGRESS_SERVICE_INDEX_W-1:0]      frm_ingress_service_index_i,
  input  wire logic [esu_pkg::VID_W-1:0]       frm_vid_i,
  input  wire logic                            frm_push_i,
  input  wire logic [esu_pkg::VID_W-1:0]       frm_push_vid_i,
  input  wire logic                            frm_routed_i,
  input  wire logic [esu_pkg::VID_W-1:0]       frm_rleg_vid_i,
  input  wire logic                            frm_dmac_mc_i,
  input  wire logic [esu_pkg::PT_W-1:0]        frm_pt_i,
  input  wire logic [esu_pkg::ACT_W-1:0]       frm_act_i,
  input  wire logic                            frm_abort_i,
  input  wire logic [1:0]                      frm_abt_src_i,
  input  wire logic [esu_pkg::LEN_W-1:0]       frm_len_i,
  input  wire logic                            match_ena_i,
  input  wire logic [esu_pkg::SVC_IDX_W-1:0]   match_base_i,
  input  wire logic [esu_pkg::SVC_IDX_W-1:0]   match_base_p_i,
  input  wire logic [ENCAP_W-1:0]              match_encap_i,
  input  wire logic [ENCAP_W-1:0]              match_encap_p_i,
  input  wire logic [MEP_W-1:0]                match_mep_i,
  input  wire logic [MEP_W-1:0]                match_mep_p_i,
  input  wire logic                            match_prot_sel_i,
  input  wire logic                            protection_active_i,
  output logic                                 match_key_prot_o,
  output logic      [ENCAP_W-1:0]              encap_idx_o,
  output logic      [MEP_W-1:0]                mep_idx_o,
  output logic                                 port_upd_o,
  output logic      [PORT_W-1:0]               port_num_o,
  output logic      [esu_pkg::PORT_IDX_W-1:0]  port_idx_o,
  output logic                                 svc_upd_o,
  output logic      [esu_pkg::SVC_IDX_W:0]     svc_idx_o,
  output logic      [esu_pkg::FRM_CNT_W-1:0]   frm_add_o,
  output logic      [esu_pkg::OCT_CNT_W-1:0]   oct_add_o
);
  logic [7:0]                  ctrl_reg, ctrl_next;
  logic [esu_pkg::DAT_W-1:0]   cos_reg, cos_next;
  logic [esu_pkg::PORT_CFG_W-1:0] port_reg [NPORT];
  logic [esu_pkg::PORT_CFG_W-1:0] port_next [NPORT];
  logic [esu_pkg::DAT_W-1:0]   wmask, rdata, dat_next;
  logic                        wr, ack_next;
  logic [1:0]                  mode;
  logic                        stk_dis, abt_en;
  logic [NPORT-1:0]            stk_en;
  logic [esu_pkg::PT_W-1:0]    xtr_pt, inj_pt;
  logic                        prot, avail, sel_ok, color;
  logic [esu_pkg::SVC_IDX_W-1:0] base, idx;
  logic                        is_xtr, is_late, is_inj, pt_ok;
  logic                        port_ok, abort_ok, svc_ok;
  logic                        kprot_next, pupd_next, supd_next;
  logic [ENCAP_W-1:0]          encap_next;
  logic [MEP_W-1:0]            mep_next;
  logic [PORT_W-1:0]           pnum_next;
  logic [esu_pkg::PORT_IDX_W-1:0] pidx_next;
  logic [esu_pkg::SVC_IDX_W:0] sidx_next;
  logic [esu_pkg::FRM_CNT_W-1:0] fadd_next;
  logic [esu_pkg::OCT_CNT_W-1:0] oadd_next;

  // Register bus: one access per request, ack one cycle later
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign mode    = ctrl_reg[esu_pkg::CTRL_MODE +: 2];
  assign stk_dis = ctrl_reg[esu_pkg::CTRL_STKDIS];
  assign abt_en  = ctrl_reg[esu_pkg::CTRL_ABTEN];
  assign xtr_pt  = port_reg[frm_port_i][esu_pkg::PORT_XTR +: esu_pkg::PT_W];
  assign inj_pt  = port_reg[frm_port_i][esu_pkg::PORT_INJ +: esu_pkg::PT_W];

  always_comb begin
    ctrl_next = ctrl_reg;
    cos_next  = cos_reg;
    if (wr && wb_adr_i == esu_pkg::A_CTRL) begin
      ctrl_next = (ctrl_reg & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
    end
    if (wr && wb_adr_i == esu_pkg::A_COS) begin
      cos_next = (cos_reg & ~wmask) | (wb_dat_i & wmask);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      localparam logic [esu_pkg::ADR_W-1:0] AD =
        esu_pkg::ADR_W'(esu_pkg::A_PORT0 + esu_pkg::REG_STRIDE * g);
      assign stk_en[g] = port_reg[g][esu_pkg::PORT_STK];
      always_comb begin
        port_next[g] = port_reg[g];
        if (wr && wb_adr_i == AD && wb_sel_i[0]) begin
          port_next[g] = wb_dat_i[esu_pkg::PORT_CFG_W-1:0];
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          port_reg[g] <= esu_pkg::PORT_RST;
        end else if (ce_i) begin
          port_reg[g] <= port_next[g];
        end
      end
    end
  endgenerate

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    rdata = '0;
    if (wb_adr_i == esu_pkg::A_CTRL) begin
      rdata = {24'h00_0000, ctrl_reg};
    end else if (wb_adr_i == esu_pkg::A_COS) begin
      rdata = cos_reg;
    end else if (wb_adr_i == esu_pkg::A_STAT) begin
      rdata = {11'h000, port_idx_o, 5'h00, svc_idx_o};
    end
    for (int p = 0; p < NPORT; p++) begin
      if (wb_adr_i ==
          esu_pkg::ADR_W'(esu_pkg::A_PORT0 + esu_pkg::REG_STRIDE * p)) begin
        rdata = {25'h000_0000, port_reg[p]};
      end
    end
    ack_next = wb_cyc_i && wb_stb_i && !wb_ack_o;
    dat_next = ack_next ? rdata : wb_dat_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= esu_pkg::CTRL_RST;
      cos_reg  <= esu_pkg::COS_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      ctrl_reg <= ctrl_next;
      cos_reg  <= cos_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= dat_next;
    end
  end

  // Protected entries swap in the alternate indexes
  assign prot  = match_prot_sel_i && protection_active_i;
  assign base  = prot ? match_base_p_i : match_base_i;
  assign avail = match_ena_i && (base != '0);

  esu_idx_sel u_sel (
    .mode_i     (mode),
    .drop_level_color_map_i   (ctrl_reg[esu_pkg::CTRL_DPMAP +: 4]),
    .dp_i       (frm_dp_i),
    .cos_i      (frm_cos_i),
    .cos_tbl_i  (cos_reg),
    .ingress_service_index_i     (frm_ingress_service_index_i),
    .vid_i      (frm_vid_i),
    .push_i     (frm_push_i),
    .push_vid_i (frm_push_vid_i),
    .routed_i   (frm_routed_i),
    .rleg_vid_i (frm_rleg_vid_i),
    .dmac_mc_i  (frm_dmac_mc_i),
    .avail_i    (avail),
    .base_i     (base),
    .idx_o      (idx),
    .color_o    (color),
    .ok_o       (sel_ok)
  );

  always_comb begin
    is_xtr  = frm_act_i == esu_pkg::ACT_XTR ||
              frm_act_i == esu_pkg::ACT_UP_ENDPOINT_EXTRACT_ACTION ||
              frm_act_i == esu_pkg::ACT_LOOPBACK_ASSEMBLY_ACTION;
    is_late = frm_act_i == esu_pkg::ACT_XTR_LATE;
    is_inj  = frm_act_i == esu_pkg::ACT_INJ ||
              frm_act_i == esu_pkg::ACT_QUEUE_LOOPBACK_ACTION;
    // A frame extracted early no longer exists at the stats point
    pt_ok = is_xtr ? (frm_pt_i >= xtr_pt) :
            is_inj ? (frm_pt_i <= inj_pt) : 1'b1;
    port_ok = !frm_abort_i && !is_xtr && !is_late;
    abort_ok = frm_abort_i &&
      (frm_abt_src_i == esu_pkg::ABT_OQS ||
       (frm_abt_src_i != esu_pkg::ABT_OAM && abt_en));
    svc_ok = frm_phys_i && sel_ok && !frm_abort_i && !is_late && pt_ok &&
             !(stk_dis && stk_en[frm_port_i]);
    kprot_next = protection_active_i;
    encap_next = prot ? match_encap_p_i : match_encap_i;
    mep_next   = prot ? match_mep_p_i : match_mep_i;
    pupd_next  = frm_vld_i && (port_ok || abort_ok);
    supd_next  = frm_vld_i && svc_ok;
    pnum_next  = frm_vld_i ? frm_port_i : port_num_o;
    pidx_next  = port_idx_o;
    sidx_next  = svc_idx_o;
    fadd_next  = esu_pkg::FRM_ONE;
    oadd_next  = oct_add_o;
    if (frm_vld_i) begin
      pidx_next = frm_abort_i ? esu_pkg::ABORT_IDX
                              : {1'b0, color, frm_prio_i};
      sidx_next = {color, idx};
      oadd_next = esu_pkg::OCT_CNT_W'(frm_len_i);
    end
  end

  // All counting happens in the shared store; only events leave here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_key_prot_o <= 1'b0;
      encap_idx_o <= '0;
      mep_idx_o   <= '0;
      port_upd_o  <= 1'b0;
      port_num_o  <= '0;
      port_idx_o  <= '0;
      svc_upd_o   <= 1'b0;
      svc_idx_o   <= '0;
      frm_add_o   <= esu_pkg::FRM_ONE;
      oct_add_o   <= '0;
    end else if (ce_i) begin
      match_key_prot_o <= kprot_next;
      encap_idx_o <= encap_next;
      mep_idx_o   <= mep_next;
      port_upd_o  <= pupd_next;
      port_num_o  <= pnum_next;
      port_idx_o  <= pidx_next;
      svc_upd_o   <= supd_next;
      svc_idx_o   <= sidx_next;
      frm_add_o   <= fadd_next;
      oct_add_o   <= oadd_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_port_tx;
    ce_i && frm_vld_i && !frm_abort_i && !is_xtr && !is_late
      |=> port_upd_o && !port_idx_o[esu_pkg::PORT_IDX_W-1];
  endproperty
  a_port_tx: assert property (p_port_tx)
    else $error("port counter missed a transmitted frame");

  property p_oqs_abort;
    ce_i && frm_vld_i && frm_abort_i && frm_abt_src_i == esu_pkg::ABT_OQS
      |=> port_upd_o && port_idx_o == esu_pkg::ABORT_IDX;
  endproperty
  a_oqs_abort: assert property (p_oqs_abort)
    else $error("queue abort not sent to abort index");

  property p_oam_abort;
    ce_i && frm_vld_i && frm_abort_i && frm_abt_src_i == esu_pkg::ABT_OAM
      |=> !port_upd_o && !svc_upd_o;
  endproperty
  a_oam_abort: assert property (p_oam_abort)
    else $error("OAM processor discard was counted");

  property p_stack;
    ce_i && frm_vld_i && stk_dis && stk_en[frm_port_i] |=> !svc_upd_o;
  endproperty
  a_stack: assert property (p_stack)
    else $error("service count on disabled stacking port");

  property p_phys;
    ce_i && frm_vld_i && !frm_phys_i |=> !svc_upd_o;
  endproperty
  a_phys: assert property (p_phys)
    else $error("service count on non-physical port");

  property p_mode1;
    ce_i && frm_vld_i && mode == esu_pkg::MODE_SVC_ONLY && !avail
      |=> !svc_upd_o;
  endproperty
  a_mode1: assert property (p_mode1)
    else $error("mode 1 counted without service index");

  property p_mode2;
    ce_i && frm_vld_i && mode == esu_pkg::MODE_INGRESS_SERVICE_INDEX
      |=> svc_idx_o == {$past(frm_dmac_mc_i),
                        $past(frm_ingress_service_index_i[esu_pkg::SVC_IDX_W-1:0])};
  endproperty
  a_mode2: assert property (p_mode2)
    else $error("mode 2 index or color wrong");

  property p_xtr_pt;
    ce_i && frm_vld_i && is_xtr && frm_pt_i < xtr_pt |=> !svc_upd_o;
  endproperty
  a_xtr_pt: assert property (p_xtr_pt)
    else $error("early extracted frame was counted");

  property p_inj_pt;
    ce_i && frm_vld_i && is_inj && frm_pt_i > inj_pt |=> !svc_upd_o;
  endproperty
  a_inj_pt: assert property (p_inj_pt)
    else $error("late injected frame was counted");

  property p_octets;
    ce_i && frm_vld_i |=> frm_add_o == esu_pkg::FRM_ONE &&
      oct_add_o == esu_pkg::OCT_CNT_W'($past(frm_len_i));
  endproperty
  a_octets: assert property (p_octets)
    else $error("frame or octet increment wrong");

  property p_prot;
    ce_i && match_prot_sel_i && protection_active_i
      |=> encap_idx_o == $past(match_encap_p_i) &&
          mep_idx_o == $past(match_mep_p_i);
  endproperty
  a_prot: assert property (p_prot)
    else $error("protection did not select alternates");

  c_vid_routed: cover property (ce_i && frm_vld_i && svc_ok &&
    mode == esu_pkg::MODE_VID && frm_routed_i ##1 svc_upd_o);
  c_rew_abort: cover property (ce_i && frm_vld_i && abort_ok &&
    frm_abt_src_i == esu_pkg::ABT_MATCH ##1 port_upd_o);
  c_prot_cnt: cover property (ce_i && frm_vld_i && prot && avail &&
    svc_ok ##1 svc_upd_o);
endmodule

//--- test/esu_stat_model.sv
// Model of the shared statistics store beside the egress statistics block.
// Assumes update pulses and increments arrive on clk_i, one frame a cycle.
`timescale 1ns/1ps
module esu_stat_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        port_upd_i,
  input  wire logic        svc_upd_i,
  input  wire logic [31:0] frm_add_i,
  input  wire logic [39:0] oct_add_i,
  output logic      [31:0] frm_tot_o,
  output logic      [39:0] oct_tot_o
);
  logic [1:0] hits;

  // Totals only; per-index storage would cost far more than it reveals
  assign hits = {1'b0, port_upd_i} + {1'b0, svc_upd_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_tot_o <= 32'h0;
      oct_tot_o <= 40'h0;
    end else begin
      // Frame and octet counters move together and wrap at width
      frm_tot_o <= frm_tot_o + frm_add_i * 32'(hits);
      oct_tot_o <= oct_tot_o + oct_add_i * 40'(hits);
    end
  end
endmodule

//--- test/esu_top_test.sv
// Self-checking bench for the egress statistics index and update block.
// Assumes the store model file is compiled first; ce_i drops once.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end \
end
module esu_top_test;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic frm_vld_i, frm_phys_i, frm_push_i, frm_routed_i, frm_dmac_mc_i;
  logic frm_abort_i, match_ena_i, match_prot_sel_i, protection_active_i;
  logic match_key_prot_o, port_upd_o, svc_upd_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, frm_add_o, frm_tot, exp_frm;
  logic [2:0]  frm_port_i, frm_prio_i, frm_cos_i, frm_pt_i, frm_act_i;
  logic [2:0]  port_num_o;
  logic [1:0]  frm_dp_i, frm_abt_src_i;
  logic [11:0] frm_ingress_service_index_i, frm_vid_i, frm_push_vid_i, frm_rleg_vid_i;
  logic [11:0] match_encap_i, match_encap_p_i, encap_idx_o;
  logic [13:0] frm_len_i;
  logic [9:0]  match_base_i, match_base_p_i;
  logic [9:0]  match_mep_i, match_mep_p_i, mep_idx_o;
  logic [4:0]  port_idx_o;
  logic [10:0] svc_idx_o;
  logic [39:0] oct_add_o, oct_tot, exp_oct;
  logic [31:0] q;
  int          error_cnt, samples_checked, cyc_cnt;

  esu_top dut (.*);
  esu_stat_model store (.clk_i(clk_i), .rst_i(rst_i),
    .port_upd_i(port_upd_o), .svc_upd_i(svc_upd_o), .frm_add_i(frm_add_o),
    .oct_add_i(oct_add_o), .frm_tot_o(frm_tot), .oct_tot_o(oct_tot));

  always #4 clk_i = ~clk_i;

  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("rdata", e, q)
  endtask

  // One frame; outputs land one edge later and are read once settled
  task automatic frm(input logic pu, input logic [4:0] pi, input logic su,
                     input logic [10:0] si);
    @(posedge clk_i);
    frm_vld_i <= 1'b1;
    @(posedge clk_i);
    frm_vld_i <= 1'b0;
    #1;
    `CHK("port_upd", pu, port_upd_o)
    `CHK("svc_upd", su, svc_upd_o)
    `CHK("frm_add", 32'h1, frm_add_o)
    `CHK("oct_add", {26'h0, frm_len_i}, oct_add_o)
    if (pu) `CHK("port_idx", pi, port_idx_o)
    if (pu) `CHK("port_num", frm_port_i, port_num_o)
    if (su) `CHK("svc_idx", si, svc_idx_o)
    exp_frm = exp_frm + pu + su;
    exp_oct = exp_oct + frm_len_i * (pu + su);
    @(posedge clk_i);
  endtask

  task automatic pa(input logic [2:0] act, input logic [2:0] pt,
                    input logic pu, input logic su);
    frm_act_i <= act;
    frm_pt_i  <= pt;
    frm(pu, 5'h0, su, 11'h2bc);
  endtask

  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, frm_vld_i} = '0;
    {frm_push_i, frm_routed_i, frm_dmac_mc_i, frm_abort_i} = '0;
    {match_ena_i, match_prot_sel_i, protection_active_i, frm_abt_src_i} = '0;
    {wb_adr_i, wb_dat_i, frm_port_i, frm_prio_i, frm_cos_i} = '0;
    {frm_pt_i, frm_act_i, frm_dp_i, frm_ingress_service_index_i, frm_vid_i} = '0;
    {frm_push_vid_i, frm_rleg_vid_i, match_encap_i, match_encap_p_i} = '0;
    {match_base_i, match_base_p_i, match_mep_i, match_mep_p_i} = '0;
    {exp_frm, exp_oct, error_cnt, samples_checked, cyc_cnt} = '0;
    {rst_i, ce_i, frm_phys_i, wb_sel_i, frm_len_i} = {3'h7, 4'hf, 14'h40};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(esu_pkg::A_CTRL, 32'hc0);
    rd(esu_pkg::A_COS, 32'h7654_3210);
    rd(esu_pkg::A_PORT0, 32'h56);
    rd(8'h0c, 32'h0);
    {match_ena_i, match_base_i, frm_cos_i, frm_dp_i} <= {1'b1, 10'h5, 5'h0a};
    {frm_prio_i, frm_len_i} <= {3'h4, 14'h3fff};
    frm(1'b1, 5'h0c, 1'b1, 11'h407);
    wb(1'b1, esu_pkg::A_COS, 32'h0000_0900);
    match_base_i <= 10'h3fa;
    frm(1'b1, 5'h0c, 1'b1, 11'h403);
    {match_base_i, frm_ingress_service_index_i, frm_dp_i, frm_prio_i} <= {10'h0, 12'hfff, 5'h0};
    frm(1'b1, 5'h00, 1'b1, 11'h3ff);
    {match_ena_i, match_base_i, frm_port_i} <= {1'b0, 10'h7, 3'h5};
    frm(1'b1, 5'h00, 1'b1, 11'h3ff);
    wb(1'b1, esu_pkg::A_CTRL, 32'hc1);
    frm(1'b1, 5'h00, 1'b0, 11'h0);
    wb(1'b1, esu_pkg::A_CTRL, 32'hc2);
    {frm_dmac_mc_i, frm_ingress_service_index_i} <= {1'b1, 12'h923};
    frm(1'b1, 5'h08, 1'b1, 11'h523);
    rd(esu_pkg::A_STAT, 32'h0008_0523);
    wb(1'b1, esu_pkg::A_CTRL, 32'hc3);
    {frm_dmac_mc_i, frm_vid_i} <= {1'b0, 12'habc};
    frm(1'b1, 5'h00, 1'b1, 11'h2bc);
    {frm_push_i, frm_push_vid_i} <= {1'b1, 12'h456};
    frm(1'b1, 5'h00, 1'b1, 11'h056);
    {frm_push_i, frm_routed_i, frm_rleg_vid_i} <= {2'b01, 12'h7ff};
    frm(1'b1, 5'h00, 1'b1, 11'h3ff);
    {frm_routed_i, frm_port_i} <= '0;
    frm_abort_i <= 1'b1;
    for (int en = 0; en < 2; en++) begin
      wb(1'b1, esu_pkg::A_CTRL, 32'hc3 | (en << 3));
      for (int s = 0; s < 4; s++) begin
        frm_abt_src_i <= 2'(s);
        frm(s == 0 || (en == 1 && s != 3), 5'h10, 1'b0, 11'h0);
      end
    end
    frm_abort_i <= 1'b0;
    pa(esu_pkg::ACT_XTR, esu_pkg::PT_IN_MIP, 1'b0, 1'b0);
    pa(esu_pkg::ACT_XTR, esu_pkg::PT_OU_SW, 1'b0, 1'b1);
    pa(esu_pkg::ACT_UP_ENDPOINT_EXTRACT_ACTION, esu_pkg::PT_OU_VOE, 1'b0, 1'b1);
    pa(esu_pkg::ACT_LOOPBACK_ASSEMBLY_ACTION, esu_pkg::PT_IN_MIP, 1'b0, 1'b0);
    pa(esu_pkg::ACT_XTR_LATE, esu_pkg::PT_VRAP, 1'b0, 1'b0);
    pa(esu_pkg::ACT_INJ, esu_pkg::PT_VRAP, 1'b1, 1'b0);
    pa(esu_pkg::ACT_INJ, esu_pkg::PT_OU_VOE, 1'b1, 1'b1);
    pa(esu_pkg::ACT_QUEUE_LOOPBACK_ACTION, esu_pkg::PT_IN_MIP, 1'b1, 1'b1);
    wb(1'b1, esu_pkg::A_PORT0, 32'h72);
    pa(esu_pkg::ACT_XTR, esu_pkg::PT_IN_MIP, 1'b0, 1'b1);
    pa(esu_pkg::ACT_INJ, esu_pkg::PT_VRAP, 1'b1, 1'b1);
    wb(1'b1, esu_pkg::A_PORT0, 32'h73);
    pa(esu_pkg::ACT_NONE, esu_pkg::PT_VRAP, 1'b1, 1'b1);
    wb(1'b1, esu_pkg::A_CTRL, 32'hc7);
    pa(esu_pkg::ACT_NONE, esu_pkg::PT_VRAP, 1'b1, 1'b0);
    // Stacking header off again so only the port kind can block counting
    wb(1'b1, esu_pkg::A_PORT0, 32'h72);
    frm_phys_i <= 1'b0;
    pa(esu_pkg::ACT_NONE, esu_pkg::PT_VRAP, 1'b1, 1'b0);
    wb(1'b1, esu_pkg::A_CTRL, 32'hc0);
    {frm_phys_i, match_ena_i} <= 2'b11;
    {match_base_i, match_base_p_i} <= {10'h001, 10'h014};
    {match_prot_sel_i, protection_active_i, frm_cos_i} <= {2'b11, 3'h0};
    {match_encap_i, match_encap_p_i} <= {12'h111, 12'h222};
    {match_mep_i, match_mep_p_i} <= {10'h0aa, 10'h155};
    frm(1'b1, 5'h00, 1'b1, 11'h014);
    `CHK("encap", 12'h222, encap_idx_o)
    `CHK("mep", 10'h155, mep_idx_o)
    `CHK("key_prot", 1'b1, match_key_prot_o)
    match_prot_sel_i <= 1'b0;
    frm(1'b1, 5'h00, 1'b1, 11'h001);
    `CHK("encap", 12'h111, encap_idx_o)
    `CHK("mep", 10'h0aa, mep_idx_o)
    // A frame offered while the enable is low must leave no event
    ce_i <= 1'b0;
    frm_vld_i <= 1'b1;
    @(posedge clk_i);
    {ce_i, frm_vld_i} <= 2'b10;
    #1;
    `CHK("frozen", 1'b0, port_upd_o)
    @(posedge clk_i);
    #1;
    `CHK("frames", exp_frm, frm_tot)
    `CHK("octets", exp_oct, oct_tot)
    finish_test();
  end
endmodule
